// >>> rtl/stall_detect_coil_switch_decode.sv
// return-to-zero control register and coil drive/routing decode for two
// stepper motors of a stall detector
// assumes a master that keeps strobes one cycle long and never overlapping
//
// Operation
// - integrate_sel set leaves the undriven coil floating, clear recirculates it.
// - integrate_sel clear holds converter reset, blanking, and clears the accumulator.
// - integrate_sel set routes undriven coil to reference and integrator inputs.
// - drive_coil_en set drives the step coil; clear turns its drivers off.
// - recirc_low_side zero recirculates on high side, one on low side.
// - node_polarity picks which undriven coil terminal feeds the integrator.
// - motor_select zero acts on motor A, one on motor B.
// - step_state 0..3 means east, north, west, south.
// - driven coil gate pairs: 00 1,4; 10 2,3; 01 5,8; 11 6,7.
// - blanking recirculation gates per step and recirc_low_side value.
// - integrating turns off undriven coil gates; no drive while integrating means all off.
// - integrate_sel clear opens all eight routing switches.
// - integrating closes the switch pair given by step and polarity.
// - each routing switch joins a fixed coil node to integrator or reference.
// - drive current is plus cosine, plus sine, minus cosine, minus sine.
// - bridge gates act only while return_zero_enable is set.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`include "rtz_params.svh"
module stall_detect_coil_switch_decode (
    input  wire logic                     mclk,
    input  wire logic                     rst,
    input  wire logic [`RTZ_ADDR_W-1:0]   regAddr,
    input  wire logic [`RTZ_DATA_W-1:0]   regWrData,
    input  wire logic                     regWrite,
    input  wire logic                     regRead,
    output logic      [`RTZ_DATA_W-1:0]   regRdData,
    output logic      [1:0][7:0]          bridgeGate,
    output logic      [1:0][7:0]          routeSwitch,
    output rtz_pkg::current_t             cosineCurrent,
    output rtz_pkg::current_t             sineCurrent,
    output logic                          converterReset,
    output logic                          accumClear
);
    import rtz_pkg::*;

    // ==================================================
    // state
    logic [`RTZ_DATA_W-1:0] ctl_q;
    logic [`RTZ_DATA_W-1:0] ctl_d;
    logic [`RTZ_DATA_W-1:0] ena_q;
    logic [`RTZ_DATA_W-1:0] ena_d;
    logic [`RTZ_DATA_W-1:0] rd_q;
    logic [`RTZ_DATA_W-1:0] rd_d;
    logic [1:0][7:0]        gate_q;
    logic [1:0][7:0]        gate_d;
    logic [1:0][7:0]        sw_q;
    logic [1:0][7:0]        sw_d;
    current_t               cos_q;
    current_t               cos_d;
    current_t               sin_q;
    current_t               sin_d;
    logic                   cnvRst_q;
    logic                   cnvRst_d;

    logic                   rtzEn;
    logic                   motorSel;
    rtz_decode_if           dif ();

    // ==================================================
    // register file next values
    always_comb begin
        ctl_d = ctl_q;
        ena_d = ena_q;
        rd_d  = 8'h00;
        if (regWrite) begin
            if (regAddr == `RTZ_CTL_OFFSET) begin
                ctl_d = regWrData & `RTZ_CTL_WMASK;
            end else if (regAddr == `RTZ_ENA_OFFSET) begin
                ena_d = regWrData & `RTZ_ENA_WMASK;
            end
        end
        if (regRead) begin
            if (regAddr == `RTZ_CTL_OFFSET) begin
                rd_d = ctl_q;
            end else if (regAddr == `RTZ_ENA_OFFSET) begin
                rd_d = ena_q;
            end else begin
                rd_d = 8'h00; // unmapped reads as zero
            end
        end
    end

    // register file flip-flops
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctl_q <= `RTZ_CTL_RESET;
            ena_q <= `RTZ_ENA_RESET;
            rd_q  <= 8'h00;
        end else begin
            ctl_q <= ctl_d;
            ena_q <= ena_d;
            rd_q  <= rd_d;
        end
    end

    assign regRdData = rd_q;

    // ==================================================
    // fields to the decoder
    assign dif.integSel  = ctl_q[`RTZ_INTEG_BIT];
    assign dif.driveEn   = ctl_q[`RTZ_DRIVE_BIT];
    assign dif.recircLow = ctl_q[`RTZ_RECIRC_BIT];
    assign dif.polarity  = ctl_q[`RTZ_POL_BIT];
    assign dif.step      = step_t'(ctl_q[`RTZ_STEP_HI:`RTZ_STEP_LO]);
    assign motorSel      = ctl_q[`RTZ_MOTOR_BIT];
    assign rtzEn         = ena_q[`RTZ_RZEN_BIT];

    rtz_coil_decode u_decode (
        .dif (dif.dec)
    );

    // ==================================================
    // per-motor steering of the decoded patterns
    generate
        for (genvar m = 0; m < 2; m++) begin : g_motor
            always_comb begin
                gate_d[m] = `GATE_NONE;
                sw_d[m]   = `SW_NONE;
                if (motorSel == 1'(m)) begin
                    // bridges released unless return to zero is on
                    gate_d[m] = rtzEn ? dif.gates : `GATE_NONE;
                    // routing follows integrate_sel regardless of enable
                    sw_d[m]   = dif.switches;
                end
            end
        end
    endgenerate

    // converter and current indication next values
    always_comb begin
        cnvRst_d = ~dif.integSel;
        cos_d    = rtzEn ? dif.cosCur : CUR_ZERO;
        sin_d    = rtzEn ? dif.sinCur : CUR_ZERO;
    end

    // output flip-flops
    always_ff @(posedge mclk) begin
        if (rst) begin
            gate_q   <= '0;
            sw_q     <= '0;
            cos_q    <= CUR_ZERO;
            sin_q    <= CUR_ZERO;
            cnvRst_q <= 1'b1;
        end else begin
            gate_q   <= gate_d;
            sw_q     <= sw_d;
            cos_q    <= cos_d;
            sin_q    <= sin_d;
            cnvRst_q <= cnvRst_d;
        end
    end

    assign bridgeGate     = gate_q;
    assign routeSwitch    = sw_q;
    assign cosineCurrent  = cos_q;
    assign sineCurrent    = sin_q;
    assign converterReset = cnvRst_q;
    assign accumClear     = cnvRst_q;

    // ==================================================
    // assertions

    // converter reset and accumulator clear follow integrate_sel
    a_conv_reset_blank: assert property (@(posedge mclk) disable iff (rst)
        !$past(ctl_q[`RTZ_INTEG_BIT]) |-> converterReset && accumClear)
        else $error("converter not held in reset during blanking");

    // no bridge gate while return to zero is off
    a_gate_idle_off: assert property (@(posedge mclk) disable iff (rst)
        !ena_q[`RTZ_RZEN_BIT] |=> bridgeGate == '0)
        else $error("bridge gates on without return to zero");

    // all switches open while blanking
    a_switch_blank_open: assert property (@(posedge mclk) disable iff (rst)
        !ctl_q[`RTZ_INTEG_BIT] |=> routeSwitch == '0)
        else $error("routing switch closed during blanking");

    // integration closes exactly two switches on the selected motor only
    a_switch_pair_count: assert property (@(posedge mclk) disable iff (rst)
        ctl_q[`RTZ_INTEG_BIT] |=>
        $countones(routeSwitch[$past(ctl_q[`RTZ_MOTOR_BIT])]) == 2 &&
        routeSwitch[~$past(ctl_q[`RTZ_MOTOR_BIT])] == 8'h00)
        else $error("integration switch pair wrong");

    // east step with drive on motor A turns on gates 1 and 4
    a_drive_east_pair: assert property (@(posedge mclk) disable iff (rst)
        ena_q[`RTZ_RZEN_BIT] && ctl_q[`RTZ_DRIVE_BIT] && !ctl_q[`RTZ_MOTOR_BIT]
        && ctl_q[1:0] == 2'h0 |=> bridgeGate[0][0] && bridgeGate[0][3]
        && !bridgeGate[0][1] && !bridgeGate[0][2])
        else $error("east drive gate pair wrong");

    // integrating without drive leaves every gate off
    a_integ_all_off: assert property (@(posedge mclk) disable iff (rst)
        ctl_q[`RTZ_INTEG_BIT] && !ctl_q[`RTZ_DRIVE_BIT] |=> bridgeGate == '0)
        else $error("gates on while integrating without drive");

    // low side recirculation on motor B, sine coil undriven
    a_recirc_low_side: assert property (@(posedge mclk) disable iff (rst)
        ena_q[`RTZ_RZEN_BIT] && !ctl_q[`RTZ_INTEG_BIT] && ctl_q[`RTZ_RECIRC_BIT]
        && ctl_q[`RTZ_MOTOR_BIT] && !ctl_q[0] |=>
        (bridgeGate[1] & 8'hF0) == 8'hA0 && bridgeGate[0] == 8'h00)
        else $error("low side recirculation gates wrong");

    // coil currents zero without drive
    a_current_no_drive: assert property (@(posedge mclk) disable iff (rst)
        !ctl_q[`RTZ_DRIVE_BIT] |=> cosineCurrent == CUR_ZERO && sineCurrent == CUR_ZERO)
        else $error("coil current without drive");

    // control register read back, bit 3 zero
    a_ctl_readback: assert property (@(posedge mclk) disable iff (rst)
        regWrite && regAddr == `RTZ_CTL_OFFSET ##1 regRead && regAddr == `RTZ_CTL_OFFSET
        |=> regRdData == ($past(regWrData, 2) & 8'hF7))
        else $error("control readback mismatch");

    // read data only in the cycle after a read strobe
    a_read_data_idle: assert property (@(posedge mclk) disable iff (rst)
        !regRead |=> regRdData == 8'h00)
        else $error("read data outside read cycle");

    // integrating releases converter and accumulator
    a_conv_run_integ: assert property (@(posedge mclk) disable iff (rst)
        ctl_q[`RTZ_INTEG_BIT] |=> !converterReset && !accumClear)
        else $error("converter held in reset while integrating");

    // north step drive on motor A turns on gates 5 and 8
    a_drive_north_pair: assert property (@(posedge mclk) disable iff (rst)
        ena_q[`RTZ_RZEN_BIT] && ctl_q[`RTZ_DRIVE_BIT] && !ctl_q[`RTZ_MOTOR_BIT] && ctl_q[1:0] == 2'h1
        |=> (bridgeGate[0] & 8'hF0) == 8'h90)
        else $error("north drive gate pair wrong");

    // west step drive on motor B turns on gates 2 and 3
    a_drive_west_pair: assert property (@(posedge mclk) disable iff (rst)
        ena_q[`RTZ_RZEN_BIT] && ctl_q[`RTZ_DRIVE_BIT] && ctl_q[`RTZ_MOTOR_BIT] && ctl_q[1:0] == 2'h2
        |=> (bridgeGate[1] & 8'h0F) == 8'h06)
        else $error("west drive gate pair wrong");

    // south step drive on motor A turns on gates 6 and 7
    a_drive_south_pair: assert property (@(posedge mclk) disable iff (rst)
        ena_q[`RTZ_RZEN_BIT] && ctl_q[`RTZ_DRIVE_BIT] && !ctl_q[`RTZ_MOTOR_BIT] && ctl_q[1:0] == 2'h3
        |=> (bridgeGate[0] & 8'hF0) == 8'h60)
        else $error("south drive gate pair wrong");

    // high side recirculation of the cosine coil on motor A
    a_recirc_high_side: assert property (@(posedge mclk) disable iff (rst)
        ena_q[`RTZ_RZEN_BIT] && !ctl_q[`RTZ_INTEG_BIT] && !ctl_q[`RTZ_RECIRC_BIT] && !ctl_q[`RTZ_MOTOR_BIT]
        && ctl_q[0] |=> (bridgeGate[0] & 8'h0F) == 8'h05)
        else $error("high side recirculation gates wrong");

    // integrating leaves the undriven sine coil without any gate
    a_integ_sine_off: assert property (@(posedge mclk) disable iff (rst)
        ctl_q[`RTZ_INTEG_BIT] && !ctl_q[0] |=> ((bridgeGate[0] | bridgeGate[1]) & 8'hF0) == 8'h00)
        else $error("undriven coil gated while integrating");

    // drive clear turns off the cosine coil on even steps
    a_drive_off_cos: assert property (@(posedge mclk) disable iff (rst)
        !ctl_q[`RTZ_DRIVE_BIT] && !ctl_q[0] |=> ((bridgeGate[0] | bridgeGate[1]) & 8'h0F) == 8'h00)
        else $error("driven coil gated with drive clear");

    // motor B untouched while motor A is selected
    a_motor_b_idle: assert property (@(posedge mclk) disable iff (rst)
        !ctl_q[`RTZ_MOTOR_BIT] |=> bridgeGate[1] == 8'h00 && routeSwitch[1] == 8'h00)
        else $error("motor B active while not selected");

    // motor A untouched while motor B is selected
    a_motor_a_idle: assert property (@(posedge mclk) disable iff (rst)
        ctl_q[`RTZ_MOTOR_BIT] |=> bridgeGate[0] == 8'h00 && routeSwitch[0] == 8'h00)
        else $error("motor A active while not selected");

    // east step, polarity zero: switches 5 and 8 on motor A
    a_switch_east_pair: assert property (@(posedge mclk) disable iff (rst)
        ctl_q[`RTZ_INTEG_BIT] && !ctl_q[`RTZ_MOTOR_BIT] && ctl_q[1:0] == 2'h0 && !ctl_q[`RTZ_POL_BIT]
        |=> routeSwitch[0] == 8'h90)
        else $error("east switch pair wrong");

    // north step, polarity one: switches 1 and 4 on motor B
    a_switch_north_pair: assert property (@(posedge mclk) disable iff (rst)
        ctl_q[`RTZ_INTEG_BIT] && ctl_q[`RTZ_MOTOR_BIT] && ctl_q[1:0] == 2'h1 && ctl_q[`RTZ_POL_BIT]
        |=> routeSwitch[1] == 8'h09)
        else $error("north switch pair wrong");

    // west step, polarity zero: switches 6 and 7 on motor B
    a_switch_west_pair: assert property (@(posedge mclk) disable iff (rst)
        ctl_q[`RTZ_INTEG_BIT] && ctl_q[`RTZ_MOTOR_BIT] && ctl_q[1:0] == 2'h2 && !ctl_q[`RTZ_POL_BIT]
        |=> routeSwitch[1] == 8'h60)
        else $error("west switch pair wrong");

    // east step drive gives positive cosine current only
    a_current_cos_pos: assert property (@(posedge mclk) disable iff (rst)
        ena_q[`RTZ_RZEN_BIT] && ctl_q[`RTZ_DRIVE_BIT] && ctl_q[1:0] == 2'h0
        |=> cosineCurrent == CUR_POS && sineCurrent == CUR_ZERO)
        else $error("east step current wrong");

    // south step drive gives negative sine current only
    a_current_sin_neg: assert property (@(posedge mclk) disable iff (rst)
        ena_q[`RTZ_RZEN_BIT] && ctl_q[`RTZ_DRIVE_BIT] && ctl_q[1:0] == 2'h3
        |=> sineCurrent == CUR_NEG && cosineCurrent == CUR_ZERO)
        else $error("south step current wrong");

    // no coil current while return to zero is off
    a_current_idle_off: assert property (@(posedge mclk) disable iff (rst)
        !ena_q[`RTZ_RZEN_BIT] |=> cosineCurrent == CUR_ZERO && sineCurrent == CUR_ZERO)
        else $error("coil current without return to zero");

    // unimplemented control bit always reads zero
    a_ctl_bit3_zero: assert property (@(posedge mclk) disable iff (rst)
        regRead && regAddr == `RTZ_CTL_OFFSET |=> !regRdData[3])
        else $error("control bit 3 reads one");

endmodule

// >>> rtl/rtz_params.svh
// constants of the return-to-zero coil controller: offsets, field positions,
// reset values and bridge/switch patterns
// assumes nothing; included by bare name where needed
`ifndef RTZ_PARAMS_SVH
`define RTZ_PARAMS_SVH

// ==================================================
// register map
`define RTZ_ADDR_W        3
`define RTZ_DATA_W        8
`define RTZ_CTL_OFFSET    3'h0
`define RTZ_ENA_OFFSET    3'h2
`define RTZ_CTL_RESET     8'h00
`define RTZ_ENA_RESET     8'h00
`define RTZ_CTL_WMASK     8'hF7
`define RTZ_ENA_WMASK     8'h80

// ==================================================
// field positions
`define RTZ_INTEG_BIT     7
`define RTZ_DRIVE_BIT     6
`define RTZ_RECIRC_BIT    5
`define RTZ_POL_BIT       4
`define RTZ_MOTOR_BIT     2
`define RTZ_STEP_HI       1
`define RTZ_STEP_LO       0
`define RTZ_RZEN_BIT      7

// ==================================================
// bridge gate patterns, bit n-1 is gate n
`define GATE_COS_POS      8'h09
`define GATE_COS_NEG      8'h06
`define GATE_SIN_POS      8'h90
`define GATE_SIN_NEG      8'h60
`define GATE_SIN_RC_HIGH  8'h50
`define GATE_SIN_RC_LOW   8'hA0
`define GATE_COS_RC_HIGH  8'h05
`define GATE_COS_RC_LOW   8'h0A
`define GATE_NONE         8'h00

// ==================================================
// routing switch patterns, bit n-1 is switch n
`define SW_S5_S8          8'h90
`define SW_S6_S7          8'h60
`define SW_S2_S3          8'h06
`define SW_S1_S4          8'h09
`define SW_NONE           8'h00

`endif

// >>> rtl/rtz_pkg.sv
// types shared by the coil controller and its decoder
// assumes the params header sits beside it
package rtz_pkg;

    // ==================================================
    // full step position
    typedef enum logic [1:0] {
        STEP_EAST  = 2'h0,
        STEP_NORTH = 2'h1,
        STEP_WEST  = 2'h2,
        STEP_SOUTH = 2'h3
    } step_t;

    // ==================================================
    // coil current direction
    typedef enum logic [1:0] {
        CUR_ZERO = 2'h0,
        CUR_POS  = 2'h1,
        CUR_NEG  = 2'h3
    } current_t;

endpackage

// >>> rtl/rtz_decode_if.sv
// carrier between the control register block and the coil decoder
// assumes rtz_pkg is compiled first
`timescale 1ns/1ps
interface rtz_decode_if;
    import rtz_pkg::*;

    logic     integSel;
    logic     driveEn;
    logic     recircLow;
    logic     polarity;
    step_t    step;
    logic     [7:0] gates;
    logic     [7:0] switches;
    current_t cosCur;
    current_t sinCur;

    // ==================================================
    // register side and decoder side
    modport ctl (output integSel, driveEn, recircLow, polarity, step,
                 input  gates, switches, cosCur, sinCur);
    modport dec (input  integSel, driveEn, recircLow, polarity, step,
                 output gates, switches, cosCur, sinCur);
endinterface

// >>> rtl/rtz_coil_decode.sv
// combinational decoder from control fields to bridge gates, routing
// switches and coil currents of one motor
// assumes the caller gates gates and currents with enable, and gates and switches with motor selection
`timescale 1ns/1ps
`include "rtz_params.svh"
module rtz_coil_decode (
    rtz_decode_if.dec dif
);
    import rtz_pkg::*;

    logic [7:0] driveMask;
    logic [7:0] recircMask;

    // ==================================================
    // gate patterns of the driven and the undriven coil
    always_comb begin
        case (dif.step)
            STEP_EAST:  driveMask = `GATE_COS_POS;
            STEP_NORTH: driveMask = `GATE_SIN_POS;
            STEP_WEST:  driveMask = `GATE_COS_NEG;
            default:    driveMask = `GATE_SIN_NEG;
        endcase
        // cosine driven on even steps, so the sine coil recirculates
        if (!dif.step[0]) begin
            recircMask = dif.recircLow ? `GATE_SIN_RC_LOW : `GATE_SIN_RC_HIGH;
        end else begin
            recircMask = dif.recircLow ? `GATE_COS_RC_LOW : `GATE_COS_RC_HIGH;
        end
        // undriven coil off while integrating, driven coil only if enabled
        dif.gates = (dif.driveEn ? driveMask : `GATE_NONE)
                  | (dif.integSel ? `GATE_NONE : recircMask);
    end

    // ==================================================
    // routing of the undriven coil to integrator and reference
    always_comb begin
        dif.switches = `SW_NONE;
        if (dif.integSel) begin
            case (dif.step)
                STEP_EAST:  dif.switches = dif.polarity ? `SW_S6_S7 : `SW_S5_S8;
                STEP_NORTH: dif.switches = dif.polarity ? `SW_S1_S4 : `SW_S2_S3;
                STEP_WEST:  dif.switches = dif.polarity ? `SW_S5_S8 : `SW_S6_S7;
                default:    dif.switches = dif.polarity ? `SW_S2_S3 : `SW_S1_S4;
            endcase
        end
    end

    // ==================================================
    // coil current directions
    always_comb begin
        dif.cosCur = CUR_ZERO;
        dif.sinCur = CUR_ZERO;
        if (dif.driveEn) begin
            case (dif.step)
                STEP_EAST:  dif.cosCur = CUR_POS;
                STEP_NORTH: dif.sinCur = CUR_POS;
                STEP_WEST:  dif.cosCur = CUR_NEG;
                default:    dif.sinCur = CUR_NEG;
            endcase
        end
    end

endmodule

// >>> verification/coil_far_side.sv
// far-side model of one stepper motor: its two coil bridges and the
// converter inputs that the routing switches join to the coil nodes
// assumes gate and switch vectors where bit n-1 stands for element n
`timescale 1ns/1ps
module coil_far_side (
    input  wire logic [7:0] gates,
    input  wire logic [7:0] switches,
    output logic      [2:0] integNode,
    output logic      [2:0] refNode,
    output rtz_pkg::current_t cosDrive,
    output rtz_pkg::current_t sinDrive
);
    import rtz_pkg::*;

    // ==================================================
    // node codes: 1 sine plus, 2 sine minus, 3 cosine plus, 4 cosine minus,
    // 7 two nodes shorted onto one converter input
    always_comb begin
        integNode = 3'h0;
        refNode   = 3'h0;
        if (switches[7]) integNode = 3'h2;
        if (switches[5]) integNode = 3'h1;
        if (switches[1]) integNode = 3'h3;
        if (switches[3]) integNode = 3'h4;
        if (switches[4]) refNode = 3'h1;
        if (switches[6]) refNode = 3'h2;
        if (switches[0]) refNode = 3'h3;
        if (switches[2]) refNode = 3'h4;
        if ($countones({switches[7], switches[5], switches[1], switches[3]}) > 1) integNode = 3'h7;
        if ($countones({switches[4], switches[6], switches[0], switches[2]}) > 1) refNode = 3'h7;
    end

    // ==================================================
    // current through each coil from the diagonal gate pair that is on
    assign cosDrive = (gates[0] & gates[3]) ? CUR_POS : ((gates[1] & gates[2]) ? CUR_NEG : CUR_ZERO);
    assign sinDrive = (gates[4] & gates[7]) ? CUR_POS : ((gates[5] & gates[6]) ? CUR_NEG : CUR_ZERO);
endmodule

// >>> verification/testbench.sv
// self-checking bench: walks every control value with enable off and on
// assumes the design's params header and package are compiled first
`timescale 1ns/1ps
`include "rtz_params.svh"
module testbench;
    import rtz_pkg::*;

    logic                   mclk;
    logic                   rst       = 1'b1;
    logic [`RTZ_ADDR_W-1:0] regAddr   = '0;
    logic [`RTZ_DATA_W-1:0] regWrData = '0;
    logic                   regWrite  = 1'b0;
    logic                   regRead   = 1'b0;
    logic [`RTZ_DATA_W-1:0] regRdData;
    logic [1:0][7:0]        bridgeGate;
    logic [1:0][7:0]        routeSwitch;
    current_t               cosineCurrent;
    current_t               sineCurrent;
    logic                   converterReset;
    logic                   accumClear;
    logic [2:0]             integNode [2];
    logic [2:0]             refNode   [2];
    current_t               cosDrive  [2];
    current_t               sinDrive  [2];
    int                     failures    = 0;
    int                     totalChecks = 0;

    stall_detect_coil_switch_decode DUT (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .bridgeGate(bridgeGate),
        .routeSwitch(routeSwitch), .cosineCurrent(cosineCurrent), .sineCurrent(sineCurrent),
        .converterReset(converterReset), .accumClear(accumClear));
    coil_far_side farA (.gates(bridgeGate[0]), .switches(routeSwitch[0]), .integNode(integNode[0]),
        .refNode(refNode[0]), .cosDrive(cosDrive[0]), .sinDrive(sinDrive[0]));
    coil_far_side farB (.gates(bridgeGate[1]), .switches(routeSwitch[1]), .integNode(integNode[1]),
        .refNode(refNode[1]), .cosDrive(cosDrive[1]), .sinDrive(sinDrive[1]));

    // ==================================================
    // clock and watchdog
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        give_verdict();
    end

    // ==================================================
    // comparison, bus and reset tasks
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        totalChecks++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [`RTZ_ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr   <= a;
        regWrData <= d;
        regWrite  <= 1'b1;
        @(posedge mclk);
        regWrite  <= 1'b0;
    endtask
    // read data stand one cycle, then fall back to zero
    task automatic rd(input logic [`RTZ_ADDR_W-1:0] a, input logic [7:0] e);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        #1;
        chk("read data", {8'h00, e}, {8'h00, regRdData});
        @(posedge mclk);
        #1;
        chk("read data idle", 16'h0000, {8'h00, regRdData});
    endtask
    // write then read with no gap between the strobes
    task automatic wrThenRd(input logic [`RTZ_ADDR_W-1:0] a, input logic [7:0] d, input logic [7:0] e);
        @(posedge mclk);
        regAddr   <= a;
        regWrData <= d;
        regWrite  <= 1'b1;
        @(posedge mclk);
        regWrite  <= 1'b0;
        regRead   <= 1'b1;
        @(posedge mclk);
        regRead   <= 1'b0;
        #1;
        chk("read after write", {8'h00, e}, {8'h00, regRdData});
    endtask
    task automatic doReset(input int n);
        @(posedge mclk);
        rst <= 1'b1;
        repeat (n - 1) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
        chk("gates after reset", 16'h0000, bridgeGate);
        chk("switches after reset", 16'h0000, routeSwitch);
        chk("converter reset", 16'h0001, {15'h0000, converterReset & accumClear});
        rd(`RTZ_CTL_OFFSET, 8'h00);
        rd(`RTZ_ENA_OFFSET, 8'h00);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", totalChecks, failures);
        if (failures == 0 && totalChecks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ==================================================
    // expected decode worked out from the step, drive and routing tables
    function automatic logic [7:0] expGates(input logic [7:0] c, input logic en);
        logic [7:0] drv;
        logic [7:0] rc;
        drv = (c[1:0] == 2'h0) ? 8'h09 : (c[1:0] == 2'h1) ? 8'h90 : (c[1:0] == 2'h2) ? 8'h06 : 8'h60;
        rc  = c[0] ? (c[5] ? 8'h0A : 8'h05) : (c[5] ? 8'hA0 : 8'h50);
        return en ? ((c[6] ? drv : 8'h00) | (c[7] ? 8'h00 : rc)) : 8'h00;
    endfunction
    function automatic logic [7:0] expSwitches(input logic [7:0] c);
        logic [7:0] tbl [8];
        tbl = '{8'h90, 8'h60, 8'h06, 8'h09, 8'h60, 8'h90, 8'h09, 8'h06};
        return c[7] ? tbl[{c[1:0], c[4]}] : 8'h00;
    endfunction

    // ==================================================
    // main sequence
    initial begin
        logic [7:0] c;
        logic       en;
        logic       sel;
        logic       minus;
        logic [2:0] base;
        current_t   ec;
        current_t   es;
        doReset(5);
        wr(3'h1, 8'hFF);
        wr(3'h7, 8'hFF);
        rd(3'h1, 8'h00);
        rd(3'h7, 8'h00);
        rd(`RTZ_CTL_OFFSET, 8'h00);
        wrThenRd(`RTZ_CTL_OFFSET, 8'h3C, 8'h34);
        for (int k = 0; k < 2; k++) begin
            en = k[0];
            wr(`RTZ_ENA_OFFSET, en ? 8'hFF : 8'h7F);
            rd(`RTZ_ENA_OFFSET, en ? 8'h80 : 8'h00);
            for (int v = 0; v < 256; v++) begin
                c = v[7:0];
                sel = c[2];
                wr(`RTZ_CTL_OFFSET, c);
                @(posedge mclk);
                #1;
                base  = c[0] ? 3'h3 : 3'h1;
                minus = ~(c[1] ^ c[0]) ^ c[4];
                ec = (en & c[6] & ~c[0]) ? (c[1] ? CUR_NEG : CUR_POS) : CUR_ZERO;
                es = (en & c[6] & c[0]) ? (c[1] ? CUR_NEG : CUR_POS) : CUR_ZERO;
                chk("gates", {8'h00, expGates(c, en)}, {8'h00, bridgeGate[sel]});
                chk("idle motor", 16'h0000, {bridgeGate[~sel], routeSwitch[~sel]});
                chk("switches", {8'h00, expSwitches(c)}, {8'h00, routeSwitch[sel]});
                chk("converter", {14'h0000, ~c[7], ~c[7]}, {14'h0000, converterReset, accumClear});
                chk("currents", {12'h000, ec, es}, {12'h000, cosineCurrent, sineCurrent});
                chk("coil drive", {12'h000, ec, es}, {12'h000, cosDrive[sel], sinDrive[sel]});
                chk("integrator node", {13'h0000, c[7] ? base + minus : 3'h0}, {13'h0000, integNode[sel]});
                chk("reference node", {13'h0000, c[7] ? base + !minus : 3'h0}, {13'h0000, refNode[sel]});
                rd(`RTZ_CTL_OFFSET, c & 8'hF7);
            end
        end
        doReset(2);
        give_verdict();
    end
endmodule
